// File: hw/cfid_pkg.sv
// Package with the feature identification register map, field layouts and values
package cfid_pkg;

    // Word byte offsets on the register bus: each 64-bit register takes two words
    localparam logic [7:0] OFS_INSTR_ATTR_ZERO_LO = 8'h00;
    localparam logic [7:0] OFS_INSTR_ATTR_ZERO_HI = 8'h04;
    localparam logic [7:0] OFS_INSTR_ATTR_ONE_LO  = 8'h08;
    localparam logic [7:0] OFS_INSTR_ATTR_ONE_HI  = 8'h0C;
    localparam logic [7:0] OFS_MEM_MODEL_ZERO_LO  = 8'h10;
    localparam logic [7:0] OFS_MEM_MODEL_ZERO_HI  = 8'h14;
    localparam logic [7:0] OFS_MEM_MODEL_ONE_LO   = 8'h18;
    localparam logic [7:0] OFS_MEM_MODEL_ONE_HI   = 8'h1C;
    localparam logic [7:0] OFS_MEM_MODEL_TWO_LO   = 8'h20;
    localparam logic [7:0] OFS_MEM_MODEL_TWO_HI   = 8'h24;
    localparam logic [7:0] OFS_DEBUG_FEAT_ZERO_LO = 8'h28;
    localparam logic [7:0] OFS_DEBUG_FEAT_ZERO_HI = 8'h2C;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 64;

    // Answer for an unmapped read
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // Field low bit positions (every field is four bits wide)
    localparam int FLD_W       = 4;
    localparam int POS_DOT     = 44;
    localparam int POS_RDM     = 28;
    localparam int POS_ATOMIC  = 20;
    localparam int POS_CRC     = 16;
    localparam int POS_SHA2    = 12;
    localparam int POS_SHA1    = 8;
    localparam int POS_AES     = 4;
    localparam int POS_WACQ    = 20;
    localparam int POS_PCLEAN  = 0;
    localparam int POS_GR_SM   = 28;
    localparam int POS_GR_LG   = 24;
    localparam int POS_GR_MD   = 20;
    localparam int POS_UMIXE   = 16;
    localparam int POS_SECSPL  = 12;
    localparam int POS_MIXE    = 8;
    localparam int POS_ASIDW   = 4;
    localparam int POS_PHYS    = 0;
    localparam int POS_S2XN    = 28;
    localparam int POS_SPECER  = 24;
    localparam int POS_PNEVER  = 20;
    localparam int POS_LOREG   = 16;
    localparam int POS_HPD     = 12;
    localparam int POS_HVIRT   = 8;
    localparam int POS_VMIDW   = 4;
    localparam int POS_HWFLAG  = 0;
    localparam int POS_VRANGE  = 16;
    localparam int POS_IBAR    = 12;
    localparam int POS_MLORD   = 8;
    localparam int POS_UOVR    = 4;
    localparam int POS_SHTAB   = 0;
    localparam int POS_DBGVER  = 0;

    // Field values
    localparam logic [3:0] V_DOT     = 4'h1;
    localparam logic [3:0] V_RDM     = 4'h1;
    localparam logic [3:0] V_ATOMIC  = 4'h2;
    localparam logic [3:0] V_CRC     = 4'h1;
    localparam logic [3:0] V_SHA2_C  = 4'h1;
    localparam logic [3:0] V_SHA1_C  = 4'h1;
    localparam logic [3:0] V_AES_C   = 4'h2;
    localparam logic [3:0] V_NONE    = 4'h0;
    localparam logic [3:0] V_WACQ    = 4'h1;
    localparam logic [3:0] V_PCLEAN  = 4'h1;
    localparam logic [3:0] V_GR_SM   = 4'h0;
    localparam logic [3:0] V_GR_LG   = 4'h0;
    localparam logic [3:0] V_GR_MD   = 4'h1;
    localparam logic [3:0] V_UMIXE   = 4'h0;
    localparam logic [3:0] V_SECSPL  = 4'h1;
    localparam logic [3:0] V_MIXE    = 4'h1;
    localparam logic [3:0] V_ASIDW   = 4'h2;
    localparam logic [3:0] V_PHYS    = 4'h2;
    localparam logic [3:0] V_S2XN    = 4'h1;
    localparam logic [3:0] V_SPECER  = 4'h0;
    localparam logic [3:0] V_PNEVER  = 4'h2;
    localparam logic [3:0] V_LOREG   = 4'h1;
    localparam logic [3:0] V_HPD     = 4'h2;
    localparam logic [3:0] V_HVIRT   = 4'h1;
    localparam logic [3:0] V_VMIDW   = 4'h2;
    localparam logic [3:0] V_HWFLAG  = 4'h2;
    localparam logic [3:0] V_VRANGE  = 4'h0;
    localparam logic [3:0] V_IBAR    = 4'h1;
    localparam logic [3:0] V_MLORD   = 4'h0;
    localparam logic [3:0] V_UOVR    = 4'h1;
    localparam logic [3:0] V_SHTAB   = 4'h1;
    localparam logic [3:0] V_DBGVER  = 4'h8;

    // Bus slave states
    typedef enum logic [1:0] {
        CFID_IDLE,
        CFID_ANSWER
    } cfid_state_t;

endpackage

// File: hw/cfid_regs.sv
// Read-only feature identification register bank behind an Avalon-MM slave
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

module cfid_regs #(
    parameter bit CRYPTO_PRESENT = 1'b0   // Cryptographic option built in
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    // Avalon-MM slave
    input  wire logic [cfid_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [cfid_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [cfid_pkg::DATA_W-1:0] avs_readdata,
    output logic                             avs_waitrequest,
    output logic      [1:0]                  avs_response,
    // External debug view of the debug feature register
    output logic      [cfid_pkg::REG_W-1:0]  external_debug_feature_view,
    // Sticky flag: a write was attempted and discarded
    output logic                             write_ignored
);
    import cfid_pkg::*;

    // Constant register images
    logic [REG_W-1:0] instr_attr_zero;    // Instruction attribute 0
    logic [REG_W-1:0] instr_attr_one;     // Instruction attribute 1
    logic [REG_W-1:0] mem_model_zero;     // Memory model 0
    logic [REG_W-1:0] mem_model_one;      // Memory model 1
    logic [REG_W-1:0] mem_model_two;      // Memory model 2
    logic [REG_W-1:0] debug_feature_zero; // Debug feature 0 (only its low field in scope)

    // Crypto-dependent field codes
    logic [3:0] sha2_code;
    logic [3:0] sha1_code;
    logic [3:0] aes_code;

    // Bus slave state
    cfid_state_t       state_ff;
    cfid_state_t       nxt_state;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic              wr_ign_ff;
    logic [DATA_W-1:0] sel_word;
    logic              hit;

    // Option-dependent codes chosen at build time
    always_comb begin
        sha2_code = CRYPTO_PRESENT ? V_SHA2_C : V_NONE;
        sha1_code = CRYPTO_PRESENT ? V_SHA1_C : V_NONE;
        aes_code  = CRYPTO_PRESENT ? V_AES_C  : V_NONE;
    end

    // Instruction attribute images; everything not set stays zero
    always_comb begin
        instr_attr_zero = '0;
        instr_attr_zero[POS_DOT+:FLD_W]    = V_DOT;
        instr_attr_zero[POS_RDM+:FLD_W]    = V_RDM;
        instr_attr_zero[POS_ATOMIC+:FLD_W] = V_ATOMIC;
        instr_attr_zero[POS_CRC+:FLD_W]    = V_CRC;
        instr_attr_zero[POS_SHA2+:FLD_W]   = sha2_code;
        instr_attr_zero[POS_SHA1+:FLD_W]   = sha1_code;
        instr_attr_zero[POS_AES+:FLD_W]    = aes_code;
        instr_attr_one = '0;
        instr_attr_one[POS_WACQ+:FLD_W]    = V_WACQ;
        instr_attr_one[POS_PCLEAN+:FLD_W]  = V_PCLEAN;
    end

    // Memory model 0 image
    always_comb begin
        mem_model_zero = '0;
        mem_model_zero[POS_GR_SM+:FLD_W]  = V_GR_SM;
        mem_model_zero[POS_GR_LG+:FLD_W]  = V_GR_LG;
        mem_model_zero[POS_GR_MD+:FLD_W]  = V_GR_MD;
        mem_model_zero[POS_UMIXE+:FLD_W]  = V_UMIXE;
        mem_model_zero[POS_SECSPL+:FLD_W] = V_SECSPL;
        mem_model_zero[POS_MIXE+:FLD_W]   = V_MIXE;
        mem_model_zero[POS_ASIDW+:FLD_W]  = V_ASIDW;
        mem_model_zero[POS_PHYS+:FLD_W]   = V_PHYS;
    end

    // Memory model 1 image
    always_comb begin
        mem_model_one = '0;
        mem_model_one[POS_S2XN+:FLD_W]   = V_S2XN;
        mem_model_one[POS_SPECER+:FLD_W] = V_SPECER;
        mem_model_one[POS_PNEVER+:FLD_W] = V_PNEVER;
        mem_model_one[POS_LOREG+:FLD_W]  = V_LOREG;
        mem_model_one[POS_HPD+:FLD_W]    = V_HPD;
        mem_model_one[POS_HVIRT+:FLD_W]  = V_HVIRT;
        mem_model_one[POS_VMIDW+:FLD_W]  = V_VMIDW;
        mem_model_one[POS_HWFLAG+:FLD_W] = V_HWFLAG;
    end

    // Memory model 2 and debug feature images
    always_comb begin
        mem_model_two = '0;
        mem_model_two[POS_VRANGE+:FLD_W] = V_VRANGE;
        mem_model_two[POS_IBAR+:FLD_W]   = V_IBAR;
        mem_model_two[POS_MLORD+:FLD_W]  = V_MLORD;
        mem_model_two[POS_UOVR+:FLD_W]   = V_UOVR;
        mem_model_two[POS_SHTAB+:FLD_W]  = V_SHTAB;
        // Other debug fields lie outside this bank and read zero here
        debug_feature_zero = '0;
        debug_feature_zero[POS_DBGVER+:FLD_W] = V_DBGVER;
    end

    // External view is the very same image, so the two can never disagree
    assign external_debug_feature_view = debug_feature_zero;

    // Word select; a miss reads zero and answers with a decode error
    always_comb begin
        hit = 1'b1;
        unique case (avs_address)
            OFS_INSTR_ATTR_ZERO_LO: sel_word = instr_attr_zero[31:0];
            OFS_INSTR_ATTR_ZERO_HI: sel_word = instr_attr_zero[63:32];
            OFS_INSTR_ATTR_ONE_LO:  sel_word = instr_attr_one[31:0];
            OFS_INSTR_ATTR_ONE_HI:  sel_word = instr_attr_one[63:32];
            OFS_MEM_MODEL_ZERO_LO:  sel_word = mem_model_zero[31:0];
            OFS_MEM_MODEL_ZERO_HI:  sel_word = mem_model_zero[63:32];
            OFS_MEM_MODEL_ONE_LO:   sel_word = mem_model_one[31:0];
            OFS_MEM_MODEL_ONE_HI:   sel_word = mem_model_one[63:32];
            OFS_MEM_MODEL_TWO_LO:   sel_word = mem_model_two[31:0];
            OFS_MEM_MODEL_TWO_HI:   sel_word = mem_model_two[63:32];
            OFS_DEBUG_FEAT_ZERO_LO: sel_word = debug_feature_zero[31:0];
            OFS_DEBUG_FEAT_ZERO_HI: sel_word = debug_feature_zero[63:32];
            default: begin
                sel_word = UNMAPPED_RD;
                hit      = 1'b0;
            end
        endcase
    end

    // Next state: every request waits one cycle, then is answered
    always_comb begin
        nxt_state = state_ff;
        nxt_rdata = rdata_ff;
        unique case (state_ff)
            CFID_IDLE: begin
                if (avs_read || avs_write) begin
                    nxt_state = CFID_ANSWER;
                    // Writes return nothing; reads register the selected word
                    nxt_rdata = avs_read ? sel_word : UNMAPPED_RD;
                end
            end
            CFID_ANSWER: begin
                nxt_state = CFID_IDLE;
            end
        endcase
    end

    // Slave state and read data flops; data is never written by the bus
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= CFID_IDLE;
            rdata_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            rdata_ff <= nxt_rdata;
        end
    end

    // Writes are accepted and dropped; a sticky flag records the attempt
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ign_ff <= 1'b0;
        end else if (state_ff == CFID_ANSWER && avs_write) begin
            wr_ign_ff <= 1'b1;
        end
    end

    // Bus outputs; waitrequest is high only while a request is up outside the answer cycle
    assign avs_waitrequest = (avs_read || avs_write) && (state_ff != CFID_ANSWER);
    assign avs_readdata    = rdata_ff;
    assign avs_response    = (state_ff == CFID_ANSWER && !hit) ? 2'h3 : 2'h0;
    assign write_ignored   = wr_ign_ff;

    // Checks next to the logic
    property p_dbg_ver;
        @(posedge ref_clk) disable iff (!arst_n)
        external_debug_feature_view[3:0] == 4'h8 && external_debug_feature_view[63:4] == '0;
    endproperty
    a_dbg_ver: assert property (p_dbg_ver) else $error("debug version wrong");

    property p_view_same;
        @(posedge ref_clk) disable iff (!arst_n)
        external_debug_feature_view == debug_feature_zero;
    endproperty
    a_view_same: assert property (p_view_same) else $error("external view differs");

    property p_isar0;
        @(posedge ref_clk) disable iff (!arst_n)
        instr_attr_zero[47:16] == 32'h1000_1021 && instr_attr_zero[63:48] == '0;
    endproperty
    a_isar0: assert property (p_isar0) else $error("instruction attribute 0 wrong");

    property p_crypto;
        @(posedge ref_clk) disable iff (!arst_n)
        instr_attr_zero[15:0] == (CRYPTO_PRESENT ? 16'h1120 : 16'h0000);
    endproperty
    a_crypto: assert property (p_crypto) else $error("crypto fields wrong");

    property p_isar1;
        @(posedge ref_clk) disable iff (!arst_n)
        instr_attr_one == 64'h0000_0000_0010_0001;
    endproperty
    a_isar1: assert property (p_isar1) else $error("instruction attribute 1 wrong");

    property p_mm0;
        @(posedge ref_clk) disable iff (!arst_n)
        mem_model_zero == 64'h0000_0000_0010_1122;
    endproperty
    a_mm0: assert property (p_mm0) else $error("memory model 0 wrong");

    property p_mm1;
        @(posedge ref_clk) disable iff (!arst_n)
        mem_model_one == 64'h0000_0000_1021_2122;
    endproperty
    a_mm1: assert property (p_mm1) else $error("memory model 1 wrong");

    property p_mm2;
        @(posedge ref_clk) disable iff (!arst_n)
        mem_model_two == 64'h0000_0000_0000_1011;
    endproperty
    a_mm2: assert property (p_mm2) else $error("memory model 2 wrong");

    property p_read_answer;
        @(posedge ref_clk) disable iff (!arst_n)
        (avs_read && state_ff == CFID_IDLE) ##1 (avs_read && !avs_waitrequest) |->
            avs_readdata == $past(sel_word);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read data mismatch");

    property p_ro_stable;
        @(posedge ref_clk) disable iff (!arst_n)
        avs_write |=> $stable(mem_model_one) && $stable(instr_attr_zero);
    endproperty
    a_ro_stable: assert property (p_ro_stable) else $error("write changed a register");

    // Readback checks: the word on the bus in the answer cycle, for the address the master still holds
    // These watch the read path as well as the images, so a decode slip shows up here
    property p_rd_dot;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_INSTR_ATTR_ZERO_HI) |->
            avs_readdata == 32'h0000_1000;
    endproperty
    a_rd_dot: assert property (p_rd_dot) else $error("dot product readback wrong");

    property p_rd_rdm;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_INSTR_ATTR_ZERO_LO) |->
            avs_readdata[31:24] == 8'h10;
    endproperty
    a_rd_rdm: assert property (p_rd_rdm) else $error("rounding MAC readback wrong");

    property p_rd_atomic;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_INSTR_ATTR_ZERO_LO) |->
            avs_readdata[23:20] == 4'h2;
    endproperty
    a_rd_atomic: assert property (p_rd_atomic) else $error("atomic readback wrong");

    property p_rd_crc;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_INSTR_ATTR_ZERO_LO) |->
            avs_readdata[19:16] == 4'h1;
    endproperty
    a_rd_crc: assert property (p_rd_crc) else $error("checksum readback wrong");

    property p_rd_crypto;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_INSTR_ATTR_ZERO_LO) |->
            avs_readdata[15:0] == (CRYPTO_PRESENT ? 16'h1120 : 16'h0000);
    endproperty
    a_rd_crypto: assert property (p_rd_crypto) else $error("crypto readback wrong");

    property p_rd_isar1;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_INSTR_ATTR_ONE_LO) |->
            avs_readdata == 32'h0010_0001;
    endproperty
    a_rd_isar1: assert property (p_rd_isar1) else $error("attribute 1 readback wrong");

    property p_rd_mm0_endian;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_MEM_MODEL_ZERO_LO) |->
            avs_readdata[19:8] == 12'h011;
    endproperty
    a_rd_mm0_endian: assert property (p_rd_mm0_endian) else $error("endian readback wrong");

    property p_rd_mm0_ids;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_MEM_MODEL_ZERO_LO) |->
            avs_readdata[7:0] == 8'h22;
    endproperty
    a_rd_mm0_ids: assert property (p_rd_mm0_ids) else $error("id width readback wrong");

    property p_rd_mm1_pan;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_MEM_MODEL_ONE_LO) |->
            avs_readdata[23:16] == 8'h21;
    endproperty
    a_rd_mm1_pan: assert property (p_rd_mm1_pan) else $error("privileged never readback wrong");

    property p_rd_mm1_low;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_MEM_MODEL_ONE_LO) |->
            avs_readdata[15:0] == 16'h2122;
    endproperty
    a_rd_mm1_low: assert property (p_rd_mm1_low) else $error("memory model 1 low readback wrong");

    property p_rd_mm2;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address == OFS_MEM_MODEL_TWO_LO) |->
            avs_readdata[11:0] == 12'h011;
    endproperty
    a_rd_mm2: assert property (p_rd_mm2) else $error("memory model 2 readback wrong");

    property p_rd_hi_zero;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_read && avs_address[2] && avs_address != OFS_INSTR_ATTR_ZERO_HI) |->
            avs_readdata == 32'h0000_0000;
    endproperty
    a_rd_hi_zero: assert property (p_rd_hi_zero) else $error("reserved upper word not zero");

    property p_wr_flag;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_ff == CFID_ANSWER && avs_write) |=>
            write_ignored;
    endproperty
    a_wr_flag: assert property (p_wr_flag) else $error("dropped write not flagged");

endmodule

// File: verification/tb_cpu_feature_id_registers.sv
// Self-checking bench for the feature identification bank, crypto and plain builds side by side
`timescale 1ns/1ps

module tb_cpu_feature_id_registers;
    import cfid_pkg::*;

    // Clock, reset and the bus drive shared by both builds
    logic              ref_clk;
    logic              arst_n;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0]        avs_byteenable;
    // Outputs of the crypto build (c) and the plain build (n)
    logic [DATA_W-1:0] rdata_c, rdata_n;
    logic              wait_c, wait_n;
    logic [1:0]        resp_c, resp_n;
    logic [REG_W-1:0]  view_c, view_n;
    logic              wig_c, wig_n;
    // Answer captured at the completing edge
    logic [DATA_W-1:0] got_c, got_n;
    logic [1:0]        rsp_c, rsp_n;
    // Bookkeeping
    int                failures;
    int                comparisons;
    int                cycles = 0;

    // Expected images in map order, assembled by hand from the field codes
    logic [63:0] exp_c [6] = '{64'h0000_1000_1021_1120, 64'h0000_0000_0010_0001, 64'h0000_0000_0010_1122,
                               64'h0000_0000_1021_2122, 64'h0000_0000_0000_1011, 64'h0000_0000_0000_0008};
    logic [63:0] exp_n [6] = '{64'h0000_1000_1021_0000, 64'h0000_0000_0010_0001, 64'h0000_0000_0010_1122,
                               64'h0000_0000_1021_2122, 64'h0000_0000_0000_1011, 64'h0000_0000_0000_0008};

    // Build with the cryptographic option
    cfid_regs #(.CRYPTO_PRESENT(1'b1)) i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(rdata_c), .avs_waitrequest(wait_c), .avs_response(resp_c),
        .external_debug_feature_view(view_c), .write_ignored(wig_c));

    // Build without it, on the same bus drive
    cfid_regs #(.CRYPTO_PRESENT(1'b0)) i_dut_nc (
        .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(rdata_n), .avs_waitrequest(wait_n), .avs_response(resp_n),
        .external_debug_feature_view(view_n), .write_ignored(wig_n));

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    // Compare a data word or response code
    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare a single flag
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon transfer; held until waitrequest is seen low, a dead slave is left to the hang guard
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address    <= a;
        avs_writedata  <= wd;
        avs_byteenable <= wr ? 4'hF : 4'h0;
        avs_read       <= ~wr;
        avs_write      <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wait_c !== 1'b0);
        // Answer lands on the second edge after the request rises
        chk_word(64'(n), 64'h2);
        chk_flag(wait_n, 1'b0);
        got_c = rdata_c;
        got_n = rdata_n;
        rsp_c = resp_c;
        rsp_n = resp_n;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // State straight after reset: no write seen, debug image on the external view
    task automatic t_reset_state();
        chk_flag(wig_c, 1'b0);
        chk_word(view_c, 64'h0000_0000_0000_0008);
        chk_word(view_n, 64'h0000_0000_0000_0008);
        $display("Test reset_state done");
    endtask

    // Every word of the map, back to back, in both builds
    task automatic t_read_map();
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk_word({32'h0, got_c}, {32'h0, exp_c[i / 2][32 * (i % 2) +: 32]});
            chk_word({32'h0, got_n}, {32'h0, exp_n[i / 2][32 * (i % 2) +: 32]});
            chk_word({62'h0, rsp_c}, 64'h0);
        end
        $display("Test read_map done");
    endtask

    // Reads past the map answer zero with a decode error and set no flag
    task automatic t_unmapped();
        bus(1'b0, 8'h30, 32'h0);
        chk_word({32'h0, got_c}, 64'h0);
        chk_word({62'h0, rsp_c}, 64'h3);
        bus(1'b0, 8'hFC, 32'h0);
        chk_word({32'h0, got_n}, 64'h0);
        chk_word({62'h0, rsp_n}, 64'h3);
        chk_flag(wig_c, 1'b0);
        $display("Test unmapped done");
    endtask

    // All-ones written everywhere must change nothing, only raise the sticky flag
    task automatic t_write_refused();
        for (int i = 0; i < 12; i++) begin
            bus(1'b1, 8'(i * 4), 32'hFFFF_FFFF);
            chk_word({62'h0, rsp_c}, 64'h0);
        end
        bus(1'b1, 8'h30, 32'hA5A5_A5A5);
        chk_flag(wig_c, 1'b1);
        chk_flag(wig_n, 1'b1);
        t_read_map();
        chk_word(view_c, 64'h0000_0000_0000_0008);
        $display("Test write_refused done");
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard; the whole sequence needs about 134 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        ref_clk        = 1'b0;
        arst_n         = 1'b0;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
        failures       = 0;
        comparisons    = 0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset_state();
        t_read_map();
        t_unmapped();
        t_write_refused();
        tally_and_finish();
    end
endmodule
